// ### rtl/psol_top.sv
// pulse, frequency and status output logic with apb registers
//
// What this block does
// - frequency mode output scales with flow, 1 kHz at upper range
// - frequency output is zero below low-flow cutoff
// - pulse count per flow quantity from pulse value and unit
// - pulse rate above 1000 Hz at upper range raises width error
// - too long width is kept as set and raises saturated warning
// - pulse frequency capped at 1/(2*width) and 1000 Hz
// - counting unit selectable among mass, volume, programmable kinds
// - configured number of pulses per accumulated counting unit
// - status output active state selectable closed or open
// - status output 1 follows exactly one selected event
// - alarm assignment asserts on any limit or self-test error
// - quadrature option drives 90 degree second train on status output
// - at or below lower range current is minimum
// - full scale at upper range, linear between
// - below minimum temperature limit raises alarm
// - maximum temperature limit evaluated for status and alarm
// - peak temperature kept, only rises, cleared only by reset
// - temperature settings all use the selected unit
// - temperature writes only in password programming mode
// - calculate request stores density reference; density on stays separate
`timescale 1ns/1ps
module psol_top
   import psol_pkg::*;
#(
   parameter logic [31:0] PASSWORD = 32'h0000_1234  // arbitrary value
) (
   // apb slave
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // clock enable
   input  wire logic        ce,
   // measurements from the same clock domain
   input  wire logic [31:0] mass_flow_rate,
   input  wire logic        flow_reverse,
   input  wire logic signed [31:0] temp,
   input  wire logic        temp_valid,
   input  wire logic        qm_min_hit,
   input  wire logic        qm_max_hit,
   input  wire logic        dens_min_hit,
   input  wire logic        dens_max_hit,
   input  wire logic        selftest_err,
   input  wire logic [31:0] cal_density,
   // outputs
   output logic             pulse_out,
   output logic             status_out,
   output logic      [15:0] temp_current,
   output logic             dens_enable
);

   typedef struct packed {
      logic [31:0] ctrl,  s_ctrl;
      logic [31:0] pulse, s_pulse;
      logic [31:0] width, s_width;
      logic [31:0] furv,  s_furv;
      logic [31:0] cut,   s_cut;
      logic [31:0] unit,  s_unit;
      logic [31:0] tlrv,  s_tlrv;
      logic [31:0] turv,  s_turv;
      logic [31:0] tmin,  s_tmin;
      logic [31:0] tmax,  s_tmax;
      logic        prog;
      logic [31:0] dref;
      logic [31:0] rdata;
      logic        stat;
   } psol_top_t;

   psol_top_t   st_ff, nxt_st;
   logic        wr_en, rd_en, hit;
   logic        width_err, saturated, pulse_a, pulse_b;
   logic        t_low, t_high, alarm, event_lvl;
   logic signed [31:0] t_peak;
   logic [15:0] cur_level;
   logic [31:0] status_word;
   psol_sel_t   sel;

   // apb is answered with no wait states
   assign pready  = 1'b1;
   assign wr_en   = psel && penable && pwrite && ce;
   assign rd_en   = psel && !penable && !pwrite && ce;
   assign pslverr = psel && penable && !hit;
   assign sel     = psol_sel_t'(st_ff.ctrl[CTRL_SEL_LSB +: 3]);

   // address decode covers word offsets only
   always_comb begin
      unique case (paddr)
         REG_CTRL, REG_PULSE, REG_WIDTH, REG_FLOW_URV, REG_CUTOFF, REG_UNIT_AMT,
         REG_T_LRV, REG_T_URV, REG_T_MIN, REG_T_MAX, REG_PASSWORD, REG_COMMIT,
         REG_STATUS, REG_T_PEAK, REG_CURRENT, REG_DENS_REF: hit = 1'b1;
         default: hit = 1'b0;
      endcase
   end

   // alarm gathers every limit and self-test fault
   assign alarm = t_low || t_high || qm_min_hit || qm_max_hit
                  || dens_min_hit || dens_max_hit || selftest_err;

   // one event drives the status output
   always_comb begin
      unique case (sel)
         SEL_FWD:    event_lvl = !flow_reverse;
         SEL_REV:    event_lvl = flow_reverse;
         SEL_QM_MIN: event_lvl = qm_min_hit;
         SEL_QM_MAX: event_lvl = qm_max_hit;
         SEL_D_MIN:  event_lvl = dens_min_hit;
         SEL_D_MAX:  event_lvl = dens_max_hit;
         SEL_ALARM:  event_lvl = alarm;
         SEL_QUAD:   event_lvl = pulse_b;
      endcase
   end

   assign status_word = {25'h000_0000, st_ff.stat, st_ff.prog, alarm,
                         t_high, t_low, saturated, width_err};

   // register writes stage; confirm copies staged to live
   always_comb begin
      nxt_st = st_ff;
      if (wr_en) begin
         unique case (paddr)
            REG_CTRL:     nxt_st.s_ctrl  = pwdata;
            REG_PULSE:    nxt_st.s_pulse = pwdata;
            REG_WIDTH:    nxt_st.s_width = pwdata;
            REG_FLOW_URV: nxt_st.s_furv  = pwdata;
            REG_CUTOFF:   nxt_st.s_cut   = pwdata;
            REG_UNIT_AMT: nxt_st.s_unit  = pwdata;
            REG_T_LRV:    if (st_ff.prog) nxt_st.s_tlrv = pwdata;
            REG_T_URV:    if (st_ff.prog) nxt_st.s_turv = pwdata;
            REG_T_MIN:    if (st_ff.prog) nxt_st.s_tmin = pwdata;
            REG_T_MAX:    if (st_ff.prog) nxt_st.s_tmax = pwdata;
            REG_PASSWORD: nxt_st.prog = (pwdata == PASSWORD);
            REG_COMMIT: begin
               if (pwdata[COMMIT_CONF]) begin
                  nxt_st.ctrl  = st_ff.s_ctrl;
                  nxt_st.pulse = st_ff.s_pulse;
                  nxt_st.width = st_ff.s_width;
                  nxt_st.furv  = st_ff.s_furv;
                  nxt_st.cut   = st_ff.s_cut;
                  nxt_st.unit  = st_ff.s_unit;
                  nxt_st.tlrv  = st_ff.s_tlrv;
                  nxt_st.turv  = st_ff.s_turv;
                  nxt_st.tmin  = st_ff.s_tmin;
                  nxt_st.tmax  = st_ff.s_tmax;
               end
               if (pwdata[COMMIT_CALC]) nxt_st.dref = cal_density;
            end
            default: ;
         endcase
      end
      // read data latched in setup so it is stable through access
      if (rd_en) begin
         unique case (paddr)
            REG_CTRL:     nxt_st.rdata = st_ff.ctrl;
            REG_PULSE:    nxt_st.rdata = st_ff.pulse;
            REG_WIDTH:    nxt_st.rdata = st_ff.width;
            REG_FLOW_URV: nxt_st.rdata = st_ff.furv;
            REG_CUTOFF:   nxt_st.rdata = st_ff.cut;
            REG_UNIT_AMT: nxt_st.rdata = st_ff.unit;
            REG_T_LRV:    nxt_st.rdata = st_ff.tlrv;
            REG_T_URV:    nxt_st.rdata = st_ff.turv;
            REG_T_MIN:    nxt_st.rdata = st_ff.tmin;
            REG_T_MAX:    nxt_st.rdata = st_ff.tmax;
            REG_PASSWORD: nxt_st.rdata = {31'h0000_0000, st_ff.prog};
            REG_STATUS:   nxt_st.rdata = status_word;
            REG_T_PEAK:   nxt_st.rdata = t_peak;
            REG_CURRENT:  nxt_st.rdata = {16'h0000, cur_level};
            REG_DENS_REF: nxt_st.rdata = st_ff.dref;
            default:      nxt_st.rdata = ZERO32;
         endcase
      end
      // open active state inverts the contact, giving break behaviour
      nxt_st.stat = event_lvl ^ st_ff.ctrl[CTRL_OPEN_BIT];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= '{ctrl: CTRL_RST, s_ctrl: CTRL_RST, pulse: PULSE_RST, s_pulse: PULSE_RST,
                    width: WIDTH_RST, s_width: WIDTH_RST, furv: FLOW_URV_RST,
                    s_furv: FLOW_URV_RST, cut: ZERO32, s_cut: ZERO32, unit: UNIT_RST,
                    s_unit: UNIT_RST, tlrv: ZERO32, s_tlrv: ZERO32, turv: T_URV_RST,
                    s_turv: T_URV_RST, tmin: ZERO32, s_tmin: ZERO32, tmax: T_MAX_RST,
                    s_tmax: T_MAX_RST, prog: 1'b0, dref: ZERO32, rdata: ZERO32,
                    stat: 1'b0};
      end else if (ce) begin
         st_ff <= nxt_st;
      end
   end

   psol_pulse_gen u_pulse (
      .pclk            (pclk),
      .presetn         (presetn),
      .ce              (ce),
      .freq_mode       (st_ff.ctrl[CTRL_MODE_BIT]),
      .flow            (mass_flow_rate),
      .flow_urv        (st_ff.furv),
      .cutoff          (st_ff.cut),
      .unit_amt        (st_ff.unit),
      .pulses_per_unit (st_ff.pulse),
      .width_ms        (st_ff.width),
      .pulse_out       (pulse_a),
      .quad_out        (pulse_b),
      .width_err       (width_err),
      .saturated       (saturated)
   );

   psol_temp_eval u_temp (
      .pclk       (pclk),
      .presetn    (presetn),
      .ce         (ce),
      .temp       (temp),
      .temp_valid (temp_valid),
      .t_lrv      (st_ff.tlrv),
      .t_urv      (st_ff.turv),
      .t_min      (st_ff.tmin),
      .t_max      (st_ff.tmax),
      .cur_level  (cur_level),
      .t_low      (t_low),
      .t_high     (t_high),
      .t_peak     (t_peak)
   );

   assign prdata       = st_ff.rdata;
   assign pulse_out    = pulse_a;
   assign status_out   = st_ff.stat;
   assign temp_current = cur_level;
   assign dens_enable  = st_ff.ctrl[CTRL_DENS_BIT];

endmodule // psol_top

// ### rtl/psol_pkg.sv
// package of constants and types for the pulse and status output block
package psol_pkg;

   // apb register byte offsets
   localparam logic [7:0] REG_CTRL     = 8'h00; // mode, unit, status select, active state
   localparam logic [7:0] REG_PULSE    = 8'h04; // pulses per counting unit
   localparam logic [7:0] REG_WIDTH    = 8'h08; // pulse width in ms
   localparam logic [7:0] REG_FLOW_URV = 8'h0C; // upper-range flow
   localparam logic [7:0] REG_CUTOFF   = 8'h10; // low-flow cutoff
   localparam logic [7:0] REG_UNIT_AMT = 8'h14; // flow quantity per counting unit
   localparam logic [7:0] REG_T_LRV    = 8'h18; // temperature lower-range value
   localparam logic [7:0] REG_T_URV    = 8'h1C; // temperature upper-range value
   localparam logic [7:0] REG_T_MIN    = 8'h20; // temperature limit min
   localparam logic [7:0] REG_T_MAX    = 8'h24; // temperature limit max
   localparam logic [7:0] REG_PASSWORD = 8'h28; // write password, read programming flag
   localparam logic [7:0] REG_COMMIT   = 8'h2C; // confirm staged settings, calc request
   localparam logic [7:0] REG_STATUS   = 8'h30; // block state, read only
   localparam logic [7:0] REG_T_PEAK   = 8'h34; // peak temperature, read only
   localparam logic [7:0] REG_CURRENT  = 8'h38; // commanded current level, read only
   localparam logic [7:0] REG_DENS_REF = 8'h3C; // stored density reference, read only

   // control register fields
   localparam int CTRL_MODE_BIT  = 0;  // 0 pulse, 1 frequency
   localparam int CTRL_UNIT_LSB  = 1;  // counting unit class, 2 bits
   localparam int CTRL_SEL_LSB   = 4;  // status output event, 3 bits
   localparam int CTRL_OPEN_BIT  = 7;  // active state open
   localparam int CTRL_TUNIT_LSB = 8;  // temperature unit, 2 bits
   localparam int CTRL_DENS_BIT  = 10; // density measurement on
   localparam int COMMIT_CONF    = 0;  // confirm staged settings
   localparam int COMMIT_CALC    = 1;  // calculate density reference

   // status register fields
   localparam int ST_WIDTH_ERR = 0;
   localparam int ST_SAT       = 1;
   localparam int ST_TMIN      = 2;
   localparam int ST_TMAX      = 3;
   localparam int ST_ALARM     = 4;
   localparam int ST_PROG      = 5;
   localparam int ST_STATUS    = 6;

   // reset values
   localparam logic [31:0] CTRL_RST     = 32'h0000_0060; // pulse mode, alarm event
   localparam logic [31:0] PULSE_RST    = 32'h0000_0001;
   localparam logic [31:0] WIDTH_RST    = 32'h0000_0032; // 50 ms
   localparam logic [31:0] FLOW_URV_RST = 32'h0000_2710;
   localparam logic [31:0] UNIT_RST     = 32'h0000_0064;
   localparam logic [31:0] T_URV_RST    = 32'h0000_005A;
   localparam logic [31:0] T_MAX_RST    = 32'h0000_00C8;
   localparam logic [31:0] T_PEAK_RST   = 32'h8000_0000; // most negative
   localparam logic [31:0] ZERO32       = 32'h0000_0000;
   localparam logic [15:0] CUR_FULL     = 16'hFFFF;

   // timing
   localparam int  CLK_HZ      = 40_000_000;
   localparam int  F_MAX_HZ    = 1000;
   localparam int  MS_CYCLES   = CLK_HZ / 1000;            // cycles per ms
   localparam int  FMAX_PERIOD = CLK_HZ / F_MAX_HZ;        // cycles at 1 kHz
   localparam int  QUAD_MAX    = FMAX_PERIOD / 4;          // cycles per quarter

   typedef enum logic [2:0] {
      SEL_FWD, SEL_REV, SEL_QM_MIN, SEL_QM_MAX,
      SEL_D_MIN, SEL_D_MAX, SEL_ALARM, SEL_QUAD
   } psol_sel_t;

   typedef enum logic [1:0] {
      UNIT_MASS, UNIT_VOL, UNIT_PROG_MASS, UNIT_PROG_VOL
   } psol_unit_t;

endpackage

// ### rtl/psol_temp_eval.sv
// temperature scaling, limits and peak store
`timescale 1ns/1ps
module psol_temp_eval
   import psol_pkg::*;
(
   // clock and reset
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               ce,
   // measured value and settings, all in the selected unit
   input  wire logic signed [31:0] temp,
   input  wire logic               temp_valid,
   input  wire logic signed [31:0] t_lrv,
   input  wire logic signed [31:0] t_urv,
   input  wire logic signed [31:0] t_min,
   input  wire logic signed [31:0] t_max,
   // results
   output logic             [15:0] cur_level,
   output logic                    t_low,
   output logic                    t_high,
   output logic signed      [31:0] t_peak
);

   typedef struct packed {
      logic [15:0]        cur;
      logic               lo;
      logic               hi;
      logic signed [31:0] peak;
   } psol_te_t;

   psol_te_t          st_ff, nxt_st;
   logic signed [32:0] span, off;
   logic        [48:0] prod;

   // linear interpolation; divider is combinational, acceptable at this slow rate
   always_comb begin
      nxt_st = st_ff;
      span   = 33'(t_urv) - 33'(t_lrv);
      off    = 33'(temp) - 33'(t_lrv);
      prod   = 49'(off[31:0]) * 49'(CUR_FULL);
      if (temp_valid) begin
         if (temp <= t_lrv) nxt_st.cur = 16'h0000;
         else if (temp >= t_urv || span <= 0) nxt_st.cur = CUR_FULL;
         else nxt_st.cur = 16'(prod / 49'(span[31:0]));
         nxt_st.lo = temp < t_min;
         nxt_st.hi = temp > t_max;
         if (temp > st_ff.peak) nxt_st.peak = temp;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= '{cur: 16'h0000, lo: 1'b0, hi: 1'b0, peak: T_PEAK_RST};
      end else if (ce) begin
         st_ff <= nxt_st;
      end
   end

   assign cur_level = st_ff.cur;
   assign t_low     = st_ff.lo;
   assign t_high    = st_ff.hi;
   assign t_peak    = st_ff.peak;

endmodule // psol_temp_eval

// ### rtl/psol_pulse_gen.sv
// pulse and frequency generator with quadrature second train
`timescale 1ns/1ps
module psol_pulse_gen
   import psol_pkg::*;
(
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        ce,
   // settings
   input  wire logic        freq_mode,
   input  wire logic [31:0] flow,
   input  wire logic [31:0] flow_urv,
   input  wire logic [31:0] cutoff,
   input  wire logic [31:0] unit_amt,
   input  wire logic [31:0] pulses_per_unit,
   input  wire logic [31:0] width_ms,
   // outputs
   output logic             pulse_out,
   output logic             quad_out,
   output logic             width_err,
   output logic             saturated
);

   typedef struct packed {
      logic [47:0] acc;
      logic [31:0] pend;
      logic [31:0] cnt;
      logic [1:0]  phase;
      logic        sat;
   } psol_pg_t;

   psol_pg_t    st_ff, nxt_st;
   logic [31:0] half, wid, max_half, need_rate;
   logic [63:0] rate_num;
   logic [47:0] acc_add, thr;

   // required half period: frequency mode scales to 1 kHz at upper range
   always_comb begin
      max_half  = 32'(FMAX_PERIOD / 2);
      wid       = 32'(64'(width_ms) * 64'(MS_CYCLES));
      rate_num  = 64'(flow_urv) * 64'(pulses_per_unit);
      need_rate = (unit_amt == 0) ? 32'hFFFF_FFFF : 32'(rate_num / 64'(unit_amt));
      if (freq_mode) begin
         half = (flow == 0) ? max_half : 32'(64'(max_half) * 64'(flow_urv) / 64'(flow));
      end else begin
         half = (wid == 0) ? 32'd1 : wid;
      end
      if (half < max_half) half = max_half;
      width_err = !freq_mode && (need_rate > 32'(F_MAX_HZ));
   end

   always_comb begin
      nxt_st  = st_ff;
      acc_add = 48'(64'(flow) * 64'(pulses_per_unit));
      thr     = 48'(unit_amt);
      if (freq_mode) begin
         nxt_st.acc  = 48'h0000_0000_0000;
         nxt_st.pend = (flow < cutoff) ? 32'h0000_0000 : 32'h0000_0001;
      end else if (thr != 0) begin
         nxt_st.acc = st_ff.acc + acc_add;
         if (nxt_st.acc >= thr) begin
            nxt_st.acc  = nxt_st.acc - thr;
            nxt_st.pend = st_ff.pend + 32'h0000_0001;
         end
      end
      // quarter steps give a 90 degree offset between the two trains
      nxt_st.cnt = st_ff.cnt + 32'h0000_0001;
      if (st_ff.cnt >= (half >> 1)) begin
         nxt_st.cnt = 32'h0000_0000;
         if (st_ff.phase != 2'd0 || st_ff.pend != 0) begin
            nxt_st.phase = st_ff.phase + 2'd1;
            if (st_ff.phase == 2'd3 && !freq_mode) nxt_st.pend = nxt_st.pend - 32'h0000_0001;
         end
      end
      // pulse width above half the 1 kHz period flags saturation
      nxt_st.sat = !freq_mode && (wid > max_half);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= '{acc: 48'h0000_0000_0000, pend: ZERO32, cnt: ZERO32,
                    phase: 2'd0, sat: 1'b0};
      end else if (ce) begin
         st_ff <= nxt_st;
      end
   end

   assign pulse_out = st_ff.phase[1];
   assign quad_out  = st_ff.phase[1] ^ st_ff.phase[0];
   assign saturated = st_ff.sat;

endmodule // psol_pulse_gen

// ### dv/psol_asserts.sv
// assertion checker for the pulse and status output block
`timescale 1ns/1ps
module psol_asserts
   import psol_pkg::*;
(
   // apb side
   input wire logic               pclk,
   input wire logic               presetn,
   input wire logic               psel,
   input wire logic               penable,
   input wire logic               pwrite,
   input wire logic        [7:0]  paddr,
   input wire logic        [31:0] pwdata,
   input wire logic        [31:0] prdata,
   input wire logic               pslverr,
   // process side
   input wire logic               ce,
   input wire logic               flow_reverse,
   input wire logic signed [31:0] temp,
   input wire logic               temp_valid,
   input wire logic               dens_min_hit,
   input wire logic               selftest_err,
   input wire logic               pulse_out,
   input wire logic               status_out,
   input wire logic               dens_enable
);
   localparam int HALF = FMAX_PERIOD / 2 - 1;
   logic        [31:0] stg_ff, live_ff, hi_ff;
   logic signed [31:0] pk_ff;
   logic               wacc, opn;
   logic        [2:0]  sel;
   assign wacc = psel && penable && ce && pwrite;
   assign sel  = live_ff[6:4];
   assign opn  = live_ff[7];
   // shadow of confirmed control, peak and high time
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stg_ff  <= CTRL_RST;
         live_ff <= CTRL_RST;
         pk_ff   <= T_PEAK_RST;
         hi_ff   <= ZERO32;
      end else begin
         if (wacc && paddr == REG_CTRL) stg_ff <= pwdata;
         if (wacc && paddr == REG_COMMIT && pwdata[COMMIT_CONF]) live_ff <= stg_ff;
         if (ce && temp_valid && temp > pk_ff) pk_ff <= temp;
         hi_ff <= pulse_out ? hi_ff + 1 : ZERO32;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_rev_follow: assert property (
      ce && sel == 3'h1 && $stable(live_ff) |=> status_out == ($past(flow_reverse) ^ $past(opn)))
      else $error("status not following reverse flow");
   chk_dmin_follow: assert property (
      ce && sel == 3'h4 && $stable(live_ff) |=> status_out == ($past(dens_min_hit) ^ $past(opn)))
      else $error("status not following density min");
   chk_alarm_sel: assert property (
      ce && sel == 3'h6 && selftest_err && $stable(live_ff) |=> status_out == !$past(opn))
      else $error("alarm not shown on status");
   chk_quad_offset: assert property (
      sel == 3'h7 && $stable(live_ff) && $changed(status_out) |-> $stable(pulse_out))
      else $error("second train edge not offset");
   chk_high_time: assert property (
      $fell(pulse_out) |-> hi_ff >= HALF)
      else $error("pulse high time below cap");
   chk_peak_read: assert property (
      ce && psel && !penable && !pwrite && paddr == REG_T_PEAK && !temp_valid
      |=> prdata == pk_ff)
      else $error("peak read mismatch");
   chk_conf_dens: assert property (
      wacc && paddr == REG_COMMIT && pwdata[COMMIT_CONF] |=> ##1 dens_enable == live_ff[10])
      else $error("density enable not confirmed");
   chk_bad_addr: assert property (
      ce && psel && penable && paddr > REG_DENS_REF |-> pslverr)
      else $error("no error on unmapped address");
endmodule // psol_asserts

// ### dv/psol_counter.sv
// pulse counter model on the far side of the pulse and status outputs
`timescale 1ns/1ps
module psol_counter (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // pulse trains from the block
   input  wire logic        pulse_in,
   input  wire logic        quad_in,
   // measurements
   output logic      [31:0] rises,
   output logic      [31:0] period,
   output logic      [31:0] lag
);
   logic [31:0] t_ff;
   logic        p_ff, q_ff;
   // sampled edge detect, as a real counter input would see it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         t_ff   <= 32'h0000_0000;
         p_ff   <= 1'b0;
         q_ff   <= 1'b0;
         rises  <= 32'h0000_0000;
         period <= 32'h0000_0000;
         lag    <= 32'h0000_0000;
      end else begin
         p_ff <= pulse_in;
         q_ff <= quad_in;
         t_ff <= t_ff + 1;
         if (pulse_in && !p_ff) begin
            rises  <= rises + 1;
            period <= t_ff;
            t_ff   <= 32'h0000_0001;
         end
         if (quad_in && !q_ff) lag <= t_ff; // lag from last main rise
      end
   end
endmodule // psol_counter

// ### dv/psol_top_tb.sv
// self-checking bench for the pulse and status output block
`timescale 1ns/1ps
module psol_top_tb
   import psol_pkg::*;
;
   localparam logic [31:0] PW = 32'h0000_5A5A; // arbitrary password
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic ce = 1'b1, flow_reverse = 1'b0, temp_valid = 1'b0, qm_min_hit = 1'b0;
   logic qm_max_hit = 1'b0, dens_min_hit = 1'b0, dens_max_hit = 1'b0, selftest_err = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = ZERO32, mass_flow_rate = 32'h0000_1388, cal_density = ZERO32;
   logic signed [31:0] temp = ZERO32;
   logic [31:0] prdata, dmy, rises, period, lag;
   logic        pready, pslverr, pulse_out, status_out, dens_enable;
   logic [15:0] temp_current;
   int          failures = 0, cmp_count = 0;
   psol_top #(.PASSWORD(PW)) i_psol_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .ce, .mass_flow_rate, .flow_reverse, .temp,
      .temp_valid, .qm_min_hit, .qm_max_hit, .dens_min_hit, .dens_max_hit, .selftest_err,
      .cal_density, .pulse_out, .status_out, .temp_current, .dens_enable);
   psol_counter i_psol_counter (.pclk, .presetn, .pulse_in(pulse_out), .quad_in(status_out),
      .rises, .period, .lag);
   // 40 mhz clock
   initial begin
      forever #12.5 pclk = ~pclk;
   end
   // one apb transfer; waits an edge first so strobes never get two writes in one step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, dmy);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      apb(1'b0, a, ZERO32, dmy);
      chk(nm, dmy, e);
   endtask
   // one sample of temperature, then let results settle
   task automatic tmp(input logic signed [31:0] v);
      temp <= v;
      temp_valid <= 1'b1;
      @(posedge pclk);
      temp_valid <= 1'b0;
      repeat (2) @(posedge pclk);
   endtask
   // event k true, reverse flow for every k but 0; k 0 is forward flow
   task automatic setev(input int k);
      flow_reverse <= (k != 0);
      qm_min_hit <= (k == 2);
      qm_max_hit <= (k == 3);
      dens_min_hit <= (k == 4);
      dens_max_hit <= (k == 5);
      selftest_err <= (k == 6);
      repeat (3) @(posedge pclk);
   endtask
   task automatic close_out;
      $display("compares %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // watchdog well past the frequency test length
   initial begin
      repeat (95000) @(posedge pclk);
      failures++;
      close_out;
   end
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd(REG_CTRL, CTRL_RST, "ctrl");
      rd(REG_WIDTH, WIDTH_RST, "width");
      rd(REG_T_MAX, T_MAX_RST, "tmax");
      rd(REG_T_PEAK, T_PEAK_RST, "peak rst");
      rd(8'h40, ZERO32, "unmapped");
      $display("test reset values done");
      wr(REG_T_MIN, 32'h0000_000A);
      wr(REG_COMMIT, 32'h0000_0001);
      rd(REG_T_MIN, ZERO32, "tmin locked");
      wr(REG_PASSWORD, PW);
      rd(REG_PASSWORD, 32'h0000_0001, "prog flag");
      wr(REG_T_MIN, 32'h0000_000A);
      wr(REG_T_MAX, 32'h0000_0096);
      rd(REG_T_MAX, T_MAX_RST, "tmax staged");
      wr(REG_COMMIT, 32'h0000_0001);
      rd(REG_T_MAX, 32'h0000_0096, "tmax live");
      rd(REG_T_MIN, 32'h0000_000A, "tmin open");
      $display("test programming gate done");
      tmp(-5);
      chk("current low", temp_current, ZERO32);
      apb(1'b0, REG_STATUS, ZERO32, dmy);
      chk("tmin flag", dmy[ST_TMIN], 1'b1);
      tmp(90);
      chk("current full", temp_current, CUR_FULL);
      tmp(250);
      apb(1'b0, REG_STATUS, ZERO32, dmy);
      chk("tmax flag", dmy[ST_TMAX], 1'b1);
      chk("alarm on", status_out, 1'b1);
      tmp(20);
      chk("alarm off", status_out, 1'b0);
      rd(REG_T_PEAK, 32'h0000_00FA, "peak");
      $display("test temperature done");
      // events 0 to 5 against selections 0 to 5
      for (int i = 0; i < 6; i++) begin
         wr(REG_CTRL, 32'(i) << 4);
         wr(REG_COMMIT, 32'h0000_0001);
         for (int k = 0; k < 6; k++) begin
            setev(k);
            chk("status sel", status_out, i == 1 ? k != 0 : i == k);
         end
      end
      wr(REG_CTRL, 32'h0000_00E0);
      wr(REG_COMMIT, 32'h0000_0001);
      setev(6);
      chk("open alarm", status_out, 1'b0);
      setev(0);
      chk("open idle", status_out, 1'b1);
      $display("test status select done");
      cal_density <= 32'h0000_03E2;
      wr(REG_COMMIT, 32'h0000_0002);
      rd(REG_DENS_REF, 32'h0000_03E2, "dens ref");
      chk("dens off", dens_enable, 1'b0);
      mass_flow_rate <= FLOW_URV_RST;
      wr(REG_CTRL, 32'h0000_0471);
      wr(REG_COMMIT, 32'h0000_0001);
      repeat (2) @(posedge pclk);
      chk("dens on", dens_enable, 1'b1);
      for (int n = 0; n < 100000 && rises < 2; n++) @(posedge pclk);
      repeat (QUAD_MAX + 200) @(posedge pclk);
      chk("period", period > 39990 && period < 40010, 1'b1);
      chk("quad lag", lag > 29990 && lag < 30020, 1'b1);
      $display("test frequency done");
      close_out;
   end
endmodule // psol_top_tb
bind psol_top psol_asserts i_psol_asserts (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .pslverr, .ce, .flow_reverse, .temp, .temp_valid, .dens_min_hit,
   .selftest_err, .pulse_out, .status_out, .dens_enable);
